// [core/cpura_regs.svh]
// Register offsets, field positions, reset values for the request arbiter.
// Assumes APB byte addresses; each register is one aligned 32-bit word.
`ifndef CPURA_REGS_SVH
`define CPURA_REGS_SVH

`define CPURA_OFF_CTRL     8'h00
`define CPURA_OFF_STATUS   8'h04
`define CPURA_OFF_COUNT_A  8'h08
`define CPURA_OFF_COUNT_B  8'h0c

`define CPURA_CTRL_CZ_EN   0
`define CPURA_CTRL_LVL_A   1
`define CPURA_CTRL_LVL_B   2
`define CPURA_CTRL_MODE_LO 4
`define CPURA_CTRL_MODE_HI 6

`define CPURA_ST_ACT_LO    0
`define CPURA_ST_ACT_HI    1
`define CPURA_ST_MODE_LO   2
`define CPURA_ST_MODE_HI   4
`define CPURA_ST_CHAN      5
`define CPURA_ST_REF_PEND  6
`define CPURA_ST_WAIT      7

`define CPURA_RST_COUNT    16'h0000
`define CPURA_COUNT_DONE   16'h0000

`endif

// [core/cpura_pkg.sv]
// Types shared by the request arbiter and its ranking stage.
// Assumes nothing beyond a SystemVerilog compiler.
package cpura_pkg;

    typedef enum logic [2:0] {
        CPURA_MODE_NORMAL = 3'h0,
        CPURA_MODE_HALT   = 3'h1,
        CPURA_MODE_PHALT  = 3'h2,
        CPURA_MODE_SLEEP  = 3'h3,
        CPURA_MODE_STOP   = 3'h4
    } cpura_mode_t;

    // Gray along idle -> refresh -> dma -> bus release
    typedef enum logic [1:0] {
        CPURA_ACT_IDLE    = 2'h0,
        CPURA_ACT_REFRESH = 2'h1,
        CPURA_ACT_DMA     = 2'h3,
        CPURA_ACT_BUSREL  = 2'h2
    } cpura_act_t;

    typedef enum logic [2:0] {
        CPURA_PICK_NONE  = 3'h0,
        CPURA_PICK_BUS   = 3'h1,
        CPURA_PICK_REF   = 3'h2,
        CPURA_PICK_DMA_A = 3'h3,
        CPURA_PICK_DMA_B = 3'h4
    } cpura_pick_t;

endpackage

// [core/cpura_rank.sv]
// Fixed-priority ranking of machine-cycle requests.
// Assumes the caller has already masked requests by mode and state.
`timescale 1ns/10ps
`default_nettype none

module cpura_rank
    import cpura_pkg::*;
(
    input  wire logic        bus_req,
    input  wire logic        ref_req,
    input  wire logic        dma_a_req,
    input  wire logic        dma_b_req,
    output cpura_pkg::cpura_pick_t pick
);

    always_comb begin
        if (bus_req) begin
            pick = CPURA_PICK_BUS;
        end else if (ref_req) begin
            pick = CPURA_PICK_REF;
        end else if (dma_a_req) begin
            pick = CPURA_PICK_DMA_A;
        end else if (dma_b_req) begin
            pick = CPURA_PICK_DMA_B;
        end else begin
            pick = CPURA_PICK_NONE;
        end
    end

endmodule

`default_nettype wire

// [core/cpura_arbiter.sv]
// Request arbiter of the processor: wait, refresh, DMA, bus release, interrupts.
// Assumes cycle and instruction boundary strobes from the sequencer, all
// inputs synchronous to clk, and an APB master for the control registers.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

`include "cpura_regs.svh"

module cpura_arbiter
    import cpura_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wait_n,
    input  wire logic        wait_sample_state,
    input  wire logic        machine_cycle,
    input  wire logic        instruction_end,
    input  wire logic        bus_request_n,
    input  wire logic        refresh_request,
    input  wire logic        dma_request_line_a,
    input  wire logic        dma_request_line_b,
    input  wire logic        nmi_n,
    input  wire logic        maskable_interrupt_input,
    output logic             wait_insert,
    output logic             bus_ack_n,
    output logic             refresh_grant,
    output logic             dma_grant,
    output logic             dma_channel,
    output logic             interrupt_accept,
    output cpura_pkg::cpura_mode_t op_mode
);

    typedef struct packed {
        cpura_act_t  act;
        cpura_mode_t op_mode;
        cpura_mode_t saved_mode;
        cpura_mode_t mode_req;
        logic        dma_chan;
        logic        ref_pend;
        logic        edge_a;
        logic        edge_b;
        logic        line_a_q;
        logic        line_b_q;
        logic        cz_en;
        logic        lvl_a;
        logic        lvl_b;
        logic [15:0] count_a;
        logic [15:0] count_b;
        logic        wait_ins;
        logic        int_acc;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } cpura_state_t;

    cpura_state_t s_reg;
    cpura_state_t s_next;
    cpura_pick_t  pick;

    logic        dma_a_live;
    logic        dma_b_live;
    logic        dma_a_ok;
    logic        dma_b_ok;
    logic        serve_all;
    logic        boundary;
    logic        cycle_done;
    logic        can_pick;
    logic        setup;
    logic        access;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == `CPURA_OFF_CTRL) || (a == `CPURA_OFF_STATUS) ||
                     (a == `CPURA_OFF_COUNT_A) || (a == `CPURA_OFF_COUNT_B);
    endfunction

    function automatic logic [31:0] read_word(input logic [7:0] a, input cpura_state_t s);
        read_word = 32'h0000_0000;
        case (a)
            `CPURA_OFF_CTRL: begin
                read_word[`CPURA_CTRL_CZ_EN] = s.cz_en;
                read_word[`CPURA_CTRL_LVL_A] = s.lvl_a;
                read_word[`CPURA_CTRL_LVL_B] = s.lvl_b;
                read_word[`CPURA_CTRL_MODE_HI:`CPURA_CTRL_MODE_LO] = s.mode_req;
            end
            `CPURA_OFF_STATUS: begin
                read_word[`CPURA_ST_ACT_HI:`CPURA_ST_ACT_LO] = s.act;
                read_word[`CPURA_ST_MODE_HI:`CPURA_ST_MODE_LO] = s.op_mode;
                read_word[`CPURA_ST_CHAN] = s.dma_chan;
                read_word[`CPURA_ST_REF_PEND] = s.ref_pend;
                read_word[`CPURA_ST_WAIT] = s.wait_ins;
            end
            `CPURA_OFF_COUNT_A: read_word[15:0] = s.count_a;
            `CPURA_OFF_COUNT_B: read_word[15:0] = s.count_b;
            default: read_word = 32'h0000_0000;
        endcase
    endfunction

    // Channel request: level on a low line, or a latched falling edge; channel A also while cz_en is set
    assign dma_a_live = (s_reg.lvl_a ? ~dma_request_line_a : s_reg.edge_a)
                        || s_reg.cz_en;
    assign dma_b_live = s_reg.lvl_b ? ~dma_request_line_b : s_reg.edge_b;

    // Zero count or NMI low stops the channel outright
    assign dma_a_ok = dma_a_live && (s_reg.count_a != `CPURA_COUNT_DONE) && nmi_n
                      && !(s_reg.act == CPURA_ACT_DMA && s_reg.lvl_a && !s_reg.cz_en);
    assign dma_b_ok = dma_b_live && (s_reg.count_b != `CPURA_COUNT_DONE) && nmi_n
                      && !(s_reg.act == CPURA_ACT_DMA && s_reg.lvl_b);

    assign serve_all = (s_reg.mode_req == CPURA_MODE_NORMAL) ||
                       (s_reg.mode_req == CPURA_MODE_HALT) ||
                       (s_reg.mode_req == CPURA_MODE_PHALT);

    // Wait stalls the boundary, so nothing lower can slip past it
    assign boundary   = machine_cycle && !(wait_sample_state && !wait_n);
    assign cycle_done = boundary && (s_reg.act == CPURA_ACT_REFRESH ||
                                     s_reg.act == CPURA_ACT_DMA);
    assign can_pick   = boundary && (s_reg.act == CPURA_ACT_IDLE || cycle_done);

    cpura_rank u_rank (
        .bus_req   (can_pick && !bus_request_n),
        .ref_req   (can_pick && serve_all && s_reg.ref_pend),
        .dma_a_req (can_pick && serve_all && dma_a_ok),
        .dma_b_req (can_pick && serve_all && dma_b_ok),
        .pick      (pick)
    );

    assign setup  = psel && !penable;
    assign access = psel && penable && s_reg.pready;

    always_comb begin
        s_next = s_reg;
        s_next.int_acc  = 1'b0;
        s_next.line_a_q = dma_request_line_a;
        s_next.line_b_q = dma_request_line_b;

        // Wait honoured only in its sampling state, never inside refresh
        s_next.wait_ins = wait_sample_state && !wait_n &&
                          (s_reg.act != CPURA_ACT_REFRESH);

        // Falling-edge latches for edge-sensed channels
        if (s_reg.line_a_q && !dma_request_line_a) begin
            s_next.edge_a = 1'b1;
        end
        if (s_reg.line_b_q && !dma_request_line_b) begin
            s_next.edge_b = 1'b1;
        end

        // Byte count steps down once per completed DMA cycle
        if (cycle_done && s_reg.act == CPURA_ACT_DMA) begin
            if (!s_reg.dma_chan) begin
                s_next.count_a = s_reg.count_a - 16'h0001;
                if (s_reg.count_a == 16'h0001) begin
                    s_next.cz_en = 1'b0;
                end
            end else begin
                s_next.count_b = s_reg.count_b - 16'h0001;
            end
        end
        if (!nmi_n) begin
            s_next.cz_en = 1'b0;
        end

        // Activity state machine
        case (s_reg.act)
            CPURA_ACT_IDLE: begin
                if (!can_pick) begin
                    s_next.op_mode = s_reg.mode_req;
                end
            end
            CPURA_ACT_REFRESH, CPURA_ACT_DMA: begin
                if (cycle_done) begin
                    s_next.act     = CPURA_ACT_IDLE;
                    s_next.op_mode = s_reg.saved_mode;
                end
            end
            CPURA_ACT_BUSREL: begin
                if (bus_request_n) begin
                    s_next.act     = CPURA_ACT_IDLE;
                    s_next.op_mode = s_reg.saved_mode;
                end
            end
            default: begin
                s_next.act = CPURA_ACT_IDLE;
            end
        endcase

        // At most one grant per boundary
        case (pick)
            CPURA_PICK_BUS: begin
                s_next.act = CPURA_ACT_BUSREL;
                if (s_reg.ref_pend || refresh_request) begin
                    s_next.ref_pend = 1'b0;
                end
            end
            CPURA_PICK_REF: begin
                s_next.act      = CPURA_ACT_REFRESH;
                s_next.ref_pend = 1'b0;
            end
            CPURA_PICK_DMA_A: begin
                s_next.act      = CPURA_ACT_DMA;
                s_next.dma_chan = 1'b0;
                s_next.edge_a   = 1'b0;
            end
            CPURA_PICK_DMA_B: begin
                s_next.act      = CPURA_ACT_DMA;
                s_next.dma_chan = 1'b1;
                s_next.edge_b   = 1'b0;
            end
            default: begin
            end
        endcase
        if (pick != CPURA_PICK_NONE && s_reg.act == CPURA_ACT_IDLE) begin
            s_next.saved_mode = s_reg.mode_req;
        end

        // New refresh request wins over a grant clear, unless bus took it
        if (refresh_request && pick != CPURA_PICK_BUS) begin
            s_next.ref_pend = 1'b1;
        end
        if (!nmi_n) begin
            s_next.edge_a = 1'b0;
            s_next.edge_b = 1'b0;
        end

        // Interrupt only at instruction end, only when nothing higher acts
        if (instruction_end && maskable_interrupt_input &&
            !(wait_sample_state && !wait_n) && pick == CPURA_PICK_NONE &&
            s_reg.act == CPURA_ACT_IDLE) begin
            s_next.int_acc = 1'b1;
        end

        // APB slave: no wait state, data prepared in setup
        s_next.pready  = setup;
        s_next.pslverr = setup && !addr_known(paddr);
        if (setup) begin
            s_next.prdata = pwrite ? 32'h0000_0000 : read_word(paddr, s_reg);
        end
        if (access && pwrite) begin
            case (paddr)
                `CPURA_OFF_CTRL: begin
                    s_next.cz_en    = pwdata[`CPURA_CTRL_CZ_EN];
                    s_next.lvl_a    = pwdata[`CPURA_CTRL_LVL_A];
                    s_next.lvl_b    = pwdata[`CPURA_CTRL_LVL_B];
                    s_next.mode_req = cpura_mode_t'(pwdata[`CPURA_CTRL_MODE_HI:`CPURA_CTRL_MODE_LO]);
                end
                `CPURA_OFF_COUNT_A: s_next.count_a = pwdata[15:0];
                `CPURA_OFF_COUNT_B: s_next.count_b = pwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg.act        <= CPURA_ACT_IDLE;
            s_reg.op_mode    <= CPURA_MODE_NORMAL;
            s_reg.saved_mode <= CPURA_MODE_NORMAL;
            s_reg.mode_req   <= CPURA_MODE_NORMAL;
            s_reg.dma_chan   <= 1'b0;
            s_reg.ref_pend   <= 1'b0;
            s_reg.edge_a     <= 1'b0;
            s_reg.edge_b     <= 1'b0;
            s_reg.line_a_q   <= 1'b1;
            s_reg.line_b_q   <= 1'b1;
            s_reg.cz_en      <= 1'b0;
            s_reg.lvl_a      <= 1'b0;
            s_reg.lvl_b      <= 1'b0;
            s_reg.count_a    <= `CPURA_RST_COUNT;
            s_reg.count_b    <= `CPURA_RST_COUNT;
            s_reg.wait_ins   <= 1'b0;
            s_reg.int_acc    <= 1'b0;
            s_reg.pready     <= 1'b0;
            s_reg.pslverr    <= 1'b0;
            s_reg.prdata     <= 32'h0000_0000;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata           = s_reg.prdata;
    assign pready           = s_reg.pready;
    assign pslverr          = s_reg.pslverr;
    assign wait_insert      = s_reg.wait_ins;
    assign bus_ack_n        = (s_reg.act != CPURA_ACT_BUSREL);
    assign refresh_grant    = (s_reg.act == CPURA_ACT_REFRESH);
    assign dma_grant        = (s_reg.act == CPURA_ACT_DMA);
    assign dma_channel      = s_reg.dma_chan;
    assign interrupt_accept = s_reg.int_acc;
    assign op_mode          = s_reg.op_mode;

endmodule

`default_nettype wire

// [bench/cpura_monitor.sv]
// Checker of arbitration outputs against their causes at the inputs.
// Assumes it is bound into cpura_arbiter and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module cpura_monitor
    import cpura_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   reset_n,
    input wire logic                   wait_n,
    input wire logic                   wait_sample_state,
    input wire logic                   machine_cycle,
    input wire logic                   instruction_end,
    input wire logic                   bus_request_n,
    input wire logic                   nmi_n,
    input wire logic                   maskable_interrupt_input,
    input wire logic                   wait_insert,
    input wire logic                   bus_ack_n,
    input wire logic                   refresh_grant,
    input wire logic                   dma_grant,
    input wire logic                   interrupt_accept,
    input wire cpura_pkg::cpura_mode_t op_mode
);
    import cpura_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Cycle end that may be taken while nothing runs
    sequence s_idle_mc;
        machine_cycle && !(wait_sample_state && !wait_n) && bus_ack_n && !refresh_grant && !dma_grant;
    endsequence
    sequence s_dma_cut;
        dma_grant && machine_cycle && !(wait_sample_state && !wait_n) && !nmi_n;
    endsequence

    a_wait_in_state: assert property ($rose(wait_insert) |-> $past(wait_sample_state && !wait_n))
        else $error("wait honoured outside its bus state");
    a_ref_at_cycle: assert property ($rose(refresh_grant) |-> $past(machine_cycle))
        else $error("refresh began off a cycle end");
    a_bus_at_cycle: assert property ($fell(bus_ack_n) |-> $past(machine_cycle && !bus_request_n))
        else $error("bus released off a cycle end");
    a_int_at_end: assert property ($rose(interrupt_accept) |-> $past(instruction_end && maskable_interrupt_input))
        else $error("interrupt taken off an instruction end");
    a_int_after_wait: assert property ($rose(interrupt_accept) |-> !$past(wait_sample_state && !wait_n))
        else $error("interrupt taken while wait held");
    a_bus_first: assert property (s_idle_mc ##0 !bus_request_n |=> !bus_ack_n && !refresh_grant)
        else $error("bus request not served first");
    a_nmi_stops: assert property (s_dma_cut |=> !dma_grant)
        else $error("dma survived nmi");
    a_one_grant: assert property ($onehot0({!bus_ack_n, refresh_grant, dma_grant}))
        else $error("two activities at once");
    a_ref_holds: assert property (refresh_grant && !machine_cycle |=> refresh_grant)
        else $error("refresh cut short");
    a_low_power: assert property ($rose(refresh_grant) || $rose(dma_grant)
        |-> !($past(op_mode) inside {CPURA_MODE_SLEEP, CPURA_MODE_STOP}))
        else $error("refresh or dma in sleep or stop");
endmodule

bind cpura_arbiter cpura_monitor cpura_monitor_i (
    .clk, .reset_n, .wait_n, .wait_sample_state, .machine_cycle, .instruction_end, .bus_request_n,
    .nmi_n, .maskable_interrupt_input, .wait_insert, .bus_ack_n, .refresh_grant, .dma_grant,
    .interrupt_accept, .op_mode
);
`default_nettype wire

// [bench/cpura_far_model.sv]
// Far side: external bus master and DMA-requesting peripherals.
// Assumes the testbench commands it through want_bus and want_dma.
`timescale 1ns/10ps
`default_nettype none

module cpura_far_model #(
    parameter int HOLD = 2
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       want_bus,
    input  wire logic [1:0] want_dma,
    input  wire logic       bus_ack_n,
    output logic            bus_request_n,
    output logic            dma_request_line_a,
    output logic            dma_request_line_b
);
    int   held;
    logic done;

    // Master keeps the bus a while after the ack, then lets go once per command
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            held <= 0;
            done <= 1'b0;
            bus_request_n <= 1'b1;
        end else if (!want_bus) begin
            done <= 1'b0;
            bus_request_n <= 1'b1;
        end else if (bus_request_n && !done) begin
            bus_request_n <= 1'b0;
            held <= 0;
        end else if (!bus_request_n && !bus_ack_n) begin
            held <= held + 1;
            if (held == HOLD) begin
                bus_request_n <= 1'b1;
                done <= 1'b1;
            end
        end
    end

    assign dma_request_line_a = !want_dma[0];
    assign dma_request_line_b = !want_dma[1];
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the request arbiter and its far-side model.
// Assumes package, register header, design and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "cpura_regs.svh"

module testbench;
    import cpura_pkg::*;
    logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        wait_n = 1'b1, wait_sample_state = 1'b0, machine_cycle = 1'b0, instruction_end = 1'b0;
    logic        refresh_request = 1'b0, nmi_n = 1'b1, maskable_interrupt_input = 1'b0, want_bus = 1'b0;
    logic [1:0]  want_dma = 2'h0;
    logic        pready, pslverr, err, bus_request_n, dma_request_line_a, dma_request_line_b;
    logic        wait_insert, bus_ack_n, refresh_grant, dma_grant, dma_channel, interrupt_accept;
    cpura_mode_t op_mode;
    int          n_errors = 0, cmp_count = 0;

    cpura_arbiter cpura_arbiter_i (
        .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .wait_n, .wait_sample_state, .machine_cycle, .instruction_end, .bus_request_n,
        .refresh_request, .dma_request_line_a, .dma_request_line_b, .nmi_n,
        .maskable_interrupt_input, .wait_insert, .bus_ack_n, .refresh_grant, .dma_grant,
        .dma_channel, .interrupt_accept, .op_mode
    );
    cpura_far_model cpura_far_model_i (
        .clk, .reset_n, .want_bus, .want_dma, .bus_ack_n, .bus_request_n, .dma_request_line_a,
        .dma_request_line_b
    );

    always #2.5 clk = ~clk;

    task automatic conclude;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic hang;
        n_errors++;
        conclude();
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
            hang();
        // Idle edge so a following call never reassigns psel in this step
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdr(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic mcyc;
        machine_cycle <= 1'b1;
        @(posedge clk);
        machine_cycle <= 1'b0;
        @(posedge clk);
    endtask
    // Refresh is latched inside, so a one-cycle pulse is enough
    task automatic ref_pulse;
        refresh_request <= 1'b1;
        tick(1);
        refresh_request <= 1'b0;
    endtask
    task automatic bus_free;
        int k = 0;
        while (bus_ack_n !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        if (bus_ack_n !== 1'b1)
            hang();
        want_bus <= 1'b0;
    endtask

    task automatic s_regs;
        chk("idle", {bus_ack_n, refresh_grant, dma_grant, interrupt_accept, wait_insert, op_mode}, 32'h80);
        rdr(`CPURA_OFF_STATUS);
        chk("status", rd, 32'h0);
        rdr(8'h20);
        chk("unmapped", {rd[30:0], err}, 32'h1);
    endtask
    task automatic s_refresh;
        ref_pulse();
        tick(3);
        chk("ref_wait", refresh_grant, 1'b0);
        mcyc();
        chk("ref_on", refresh_grant, 1'b1);
        tick(4);
        chk("ref_hold", refresh_grant, 1'b1);
        mcyc();
        chk("ref_off", refresh_grant, 1'b0);
    endtask
    task automatic s_bus;
        want_bus <= 1'b1;
        ref_pulse();
        mcyc();
        chk("bus_first", {bus_ack_n, refresh_grant}, 2'b00);
        bus_free();
        mcyc();
        chk("ref_dropped", refresh_grant, 1'b0);
    endtask
    task automatic s_dma;
        logic [4:0] pat = 5'b00101;
        wr(`CPURA_OFF_CTRL, 32'h2);
        wr(`CPURA_OFF_COUNT_A, 32'h2);
        want_dma <= 2'b01;
        ref_pulse();
        mcyc();
        chk("ref_over_dma", {refresh_grant, dma_grant}, 2'b10);
        for (int i = 0; i < 5; i++) begin
            mcyc();
            chk("dma_a", dma_grant, pat[i]);
        end
        rdr(`CPURA_OFF_COUNT_A);
        chk("count_a", rd, 32'h0);
        wr(`CPURA_OFF_COUNT_B, 32'h5);
        wr(`CPURA_OFF_CTRL, 32'h4);
        want_dma <= 2'b10;
        mcyc();
        chk("dma_b", {dma_grant, dma_channel}, 2'b11);
        mcyc();
        want_dma <= 2'b00;
        mcyc();
        chk("line_high", dma_grant, 1'b0);
        wr(`CPURA_OFF_COUNT_A, 32'h3);
        wr(`CPURA_OFF_CTRL, 32'h1);
        mcyc();
        chk("zero_en", dma_grant, 1'b1);
        nmi_n <= 1'b0;
        mcyc();
        chk("nmi_end", dma_grant, 1'b0);
        nmi_n <= 1'b1;
        rdr(`CPURA_OFF_CTRL);
        chk("zero_en_clr", rd[0], 1'b0);
    endtask
    task automatic s_modes;
        for (int m = 1; m < 5; m++) begin
            wr(`CPURA_OFF_CTRL, 32'(m) << 4);
            ref_pulse();
            mcyc();
            chk("mode_ref", refresh_grant, m < 3);
            mcyc();
            chk("mode_back", op_mode, m);
        end
        want_bus <= 1'b1;
        tick(1);
        mcyc();
        chk("stop_bus", bus_ack_n, 1'b0);
        bus_free();
        chk("stop_back", op_mode, CPURA_MODE_STOP);
        wr(`CPURA_OFF_CTRL, 32'h0);
        mcyc();
        chk("ref_cleared", refresh_grant, 1'b0);
    endtask
    task automatic s_wait_int;
        wait_n <= 1'b0;
        maskable_interrupt_input <= 1'b1;
        tick(2);
        chk("wait_off", wait_insert, 1'b0);
        wait_sample_state <= 1'b1;
        tick(2);
        chk("wait_on", wait_insert, 1'b1);
        ref_pulse();
        mcyc();
        chk("wait_mc", refresh_grant, 1'b0);
        instruction_end <= 1'b1;
        tick(1);
        instruction_end <= 1'b0;
        tick(1);
        chk("wait_int", interrupt_accept, 1'b0);
        wait_n <= 1'b1;
        wait_sample_state <= 1'b0;
        tick(3);
        chk("int_no_end", interrupt_accept, 1'b0);
        mcyc();
        chk("mc_after", refresh_grant, 1'b1);
        mcyc();
        instruction_end <= 1'b1;
        tick(1);
        instruction_end <= 1'b0;
        tick(1);
        chk("int_on", interrupt_accept, 1'b1);
        ref_pulse();
        machine_cycle <= 1'b1;
        instruction_end <= 1'b1;
        tick(1);
        machine_cycle <= 1'b0;
        instruction_end <= 1'b0;
        tick(1);
        chk("mc_over_int", {refresh_grant, interrupt_accept}, 2'b10);
        mcyc();
        maskable_interrupt_input <= 1'b0;
    endtask

    initial begin
        tick(3);
        reset_n <= 1'b1;
        tick(1);
        s_regs();
        s_refresh();
        s_bus();
        s_dma();
        s_modes();
        s_wait_int();
        conclude();
    end
endmodule
`default_nettype wire
